// ===== hdl/crac_cell_register.sv
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module crac_cell_register (
  // Clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       reset_i,
  // Register bus
  input  wire crac_pkg::crac_ahb_req_type ahb_req_i,
  output var  crac_pkg::crac_ahb_rsp_type ahb_rsp_o,
  // Cell control pins
  input  wire logic                       block_control_one_i,
  input  wire logic                       block_control_two_i,
  input  wire logic                       async_load_data_i,
  input  wire logic                       cell_data_i,
  input  wire logic                       chip_reset_n_i,
  input  wire logic [5:0]                 dedicated_i,
  // Pin cell pad
  input  wire logic                       pad_i,
  output logic                            pad_o,
  output logic                            pad_oe_n_o,
  // Cell outputs
  output logic                            cell_q_o,
  output logic                            pin_in_q_o
);

  // ****************************************
  // Registers and synchronisers
  // ****************************************
  crac_pkg::crac_ctrl_type                ctrl;
  logic [crac_pkg::ROLES_W-1:0]           roles;
  logic [crac_pkg::SYNC_W-1:0]            sync_meta;
  logic [crac_pkg::SYNC_W-1:0]            sync;
  logic [crac_pkg::DED_COUNT-1:0]         ded;
  logic                                   clk_pin_prev;
  logic                                   raw_q;
  logic                                   pin_q;
  logic                                   in_adj_q;
  logic                                   oe_adj_q;
  logic                                   wr_pend;
  logic [7:0]                             wr_addr;

  function automatic logic role_hit(
    input logic [crac_pkg::DED_COUNT-1:0] pins,
    input logic [crac_pkg::ROLES_W-1:0]   sel,
    input crac_pkg::crac_role_type        role,
    input logic                           want_used
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < crac_pkg::DED_COUNT; i++)
    begin
      if (sel[i*crac_pkg::ROLE_W +: crac_pkg::ROLE_W] == role)
      begin
        hit = hit | (want_used ? 1'b1 : pins[i]);
      end
    end
    return hit;
  endfunction

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      sync_meta <= '0;
      sync      <= '0;
    end
    else
    begin
      sync_meta <= {chip_reset_n_i, dedicated_i, pad_i, cell_data_i,
                    async_load_data_i, block_control_two_i, block_control_one_i};
      sync      <= sync_meta;
    end
  end

  // ****************************************
  // Dedicated low-skew inputs
  // ****************************************
  logic g_clear;
  logic g_preset;
  logic g_oe;
  logic g_ce;
  logic g_ce_used;
  logic g_clk;
  logic g_clk_used;
  logic chip_rst;
  logic capture;

  assign ded        = sync[crac_pkg::SYNC_DED +: crac_pkg::DED_COUNT];
  assign g_clear    = role_hit(ded, roles, crac_pkg::ROLE_CLEAR, 1'b0);
  assign g_preset   = role_hit(ded, roles, crac_pkg::ROLE_PRESET, 1'b0);
  assign g_oe       = role_hit(ded, roles, crac_pkg::ROLE_OE, 1'b0);
  assign g_ce       = role_hit(ded, roles, crac_pkg::ROLE_CLK_EN, 1'b0);
  assign g_ce_used  = role_hit(ded, roles, crac_pkg::ROLE_CLK_EN, 1'b1);
  assign g_clk      = role_hit(ded, roles, crac_pkg::ROLE_CLOCK, 1'b0);
  assign g_clk_used = role_hit(ded, roles, crac_pkg::ROLE_CLOCK, 1'b1);
  assign chip_rst   = ctrl.chip_rst_en & ~sync[crac_pkg::SYNC_W-1];

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      clk_pin_prev <= 1'b0;
    end
    else
    begin
      clk_pin_prev <= g_clk;
    end
  end

  // Global clock rising edge, else every cycle; gated by clock enable
  assign capture = (g_clk_used ? (g_clk & ~clk_pin_prev) : 1'b1)
                 & ctrl.clk_en & (~g_ce_used | g_ce);

  // ****************************************
  // Logic cell clear and preset steering
  // ****************************************
  logic bc1;
  logic bc2;
  logic ald;
  logic inverted;
  logic prn_n;
  logic clrn_n;
  logic next_raw;

  assign bc1      = sync[crac_pkg::SYNC_BC1];
  assign bc2      = sync[crac_pkg::SYNC_BC2];
  assign ald      = sync[crac_pkg::SYNC_ALD];
  assign inverted = (ctrl.mode == crac_pkg::MODE_PRESET_INV)
                  | (ctrl.mode == crac_pkg::MODE_LOAD_PRESET);

  always_comb
  begin
    prn_n  = 1'b1;
    clrn_n = 1'b1;
    unique case (ctrl.mode)
      crac_pkg::MODE_CLEAR:
      begin
        clrn_n = ~(bc1 | bc2);
      end
      crac_pkg::MODE_PRESET_LOAD:
      begin
        prn_n = ~bc1;
      end
      crac_pkg::MODE_PRESET_INV:
      begin
        clrn_n = ~bc1;
      end
      crac_pkg::MODE_PRESET_CLEAR:
      begin
        prn_n  = ~bc1;
        clrn_n = ~bc2;
      end
      crac_pkg::MODE_LOAD_CLEAR:
      begin
        prn_n  = ~(bc1 & ald);
        clrn_n = ~((bc1 & ~ald) | bc2);
      end
      crac_pkg::MODE_LOAD_PRESET:
      begin
        prn_n  = ~(bc1 & ~ald);
        clrn_n = ~((bc1 & ald) | bc2);
      end
      crac_pkg::MODE_LOAD_ONLY:
      begin
        prn_n  = ~(bc1 & ald);
        clrn_n = ~(bc1 & ~ald);
      end
      default:
      begin
        clrn_n = ~(bc1 | bc2);
      end
    endcase
    // Global clear and preset act on the visible output value
    if (inverted ? g_preset : g_clear)
    begin
      clrn_n = 1'b0;
    end
    if (inverted ? g_clear : g_preset)
    begin
      prn_n = 1'b0;
    end
  end

  always_comb
  begin
    if (chip_rst)
    begin
      next_raw = 1'b0;
    end
    else if (!clrn_n)
    begin
      next_raw = 1'b0;
    end
    else if (!prn_n)
    begin
      next_raw = 1'b1;
    end
    else if (capture)
    begin
      next_raw = sync[crac_pkg::SYNC_DATA] ^ inverted;
    end
    else
    begin
      next_raw = raw_q;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      raw_q    <= 1'b0;
      cell_q_o <= 1'b0;
    end
    else
    begin
      raw_q    <= next_raw;
      cell_q_o <= next_raw ^ inverted;
    end
  end

  // ****************************************
  // Pin cell and adjacent registers
  // ****************************************
  logic pad_in;
  logic is_out;
  logic is_bidir;
  logic next_pin;
  logic next_oe;

  assign pad_in   = sync[crac_pkg::SYNC_PAD] ^ ctrl.in_inv;
  assign is_out   = ctrl.pin_mode != crac_pkg::PIN_INPUT;
  assign is_bidir = ctrl.pin_mode == crac_pkg::PIN_BIDIR;

  always_comb
  begin
    if (chip_rst || g_clear)
    begin
      next_pin = 1'b0;
    end
    else if (g_preset)
    begin
      next_pin = 1'b1;
    end
    else if (capture)
    begin
      next_pin = is_out ? (cell_q_o ^ ctrl.out_inv) : pad_in;
    end
    else
    begin
      next_pin = pin_q;
    end
    next_oe = is_out & ~chip_rst & (capture ? (ctrl.oe | g_oe) : oe_adj_q);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      pin_q      <= 1'b0;
      in_adj_q   <= 1'b0;
      oe_adj_q   <= 1'b0;
      pad_o      <= 1'b0;
      pad_oe_n_o <= 1'b1;
      pin_in_q_o <= 1'b0;
    end
    else
    begin
      pin_q    <= next_pin;
      oe_adj_q <= next_oe;
      if (chip_rst || !is_bidir)
      begin
        in_adj_q <= 1'b0;
      end
      else if (capture)
      begin
        in_adj_q <= pad_in;
      end
      pad_o      <= is_out & next_pin;
      pad_oe_n_o <= ~next_oe;
      pin_in_q_o <= is_bidir ? in_adj_q : (is_out ? 1'b0 : next_pin);
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic [31:0] status;
  logic        take;

  assign status = {22'h0, g_ce, ded, oe_adj_q, pin_q, cell_q_o};
  assign take   = ahb_req_i.hsel & ahb_req_i.hready
                & (ahb_req_i.htrans == crac_pkg::HTRANS_NONSEQ_BIT);

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      ahb_rsp_o <= '{hreadyout: 1'b1, hrdata: 32'h0000_0000, hresp: 1'b0};
    end
    else
    begin
      wr_pend <= take & ahb_req_i.hwrite & (ahb_req_i.haddr[31:8] == 24'h00_0000);
      wr_addr <= ahb_req_i.haddr[7:0];
      ahb_rsp_o.hreadyout <= 1'b1;
      ahb_rsp_o.hresp     <= 1'b0;
      if (take && !ahb_req_i.hwrite && ahb_req_i.haddr[31:8] == 24'h00_0000)
      begin
        unique case (ahb_req_i.haddr[7:0])
          crac_pkg::CTRL_OFFSET:   ahb_rsp_o.hrdata <= {22'h0, ctrl};
          crac_pkg::ROLE_OFFSET:   ahb_rsp_o.hrdata <= {14'h0, roles};
          crac_pkg::STATUS_OFFSET: ahb_rsp_o.hrdata <= status;
          default:                 ahb_rsp_o.hrdata <= 32'h0000_0000;
        endcase
      end
      else
      begin
        ahb_rsp_o.hrdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      ctrl  <= crac_pkg::crac_ctrl_type'(crac_pkg::CTRL_RESET[crac_pkg::CTRL_W-1:0]);
      roles <= crac_pkg::ROLE_RESET[crac_pkg::ROLES_W-1:0];
    end
    else if (wr_pend && wr_addr == crac_pkg::CTRL_OFFSET)
    begin
      ctrl <= crac_pkg::crac_ctrl_type'(ahb_req_i.hwdata[crac_pkg::CTRL_W-1:0]);
    end
    else if (wr_pend && wr_addr == crac_pkg::ROLE_OFFSET)
    begin
      roles <= ahb_req_i.hwdata[crac_pkg::ROLES_W-1:0];
    end
  end

endmodule // crac_cell_register
`default_nettype wire

// ===== hdl/crac_pkg.sv
`default_nettype none
package crac_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]  ROLE_OFFSET   = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET = 8'h08;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0100;
  localparam logic [31:0] ROLE_RESET    = 32'h0000_0000;
  localparam int          CTRL_W        = 10;

  // ****************************************
  // Sizes and field positions
  // ****************************************
  localparam int DED_COUNT = 6;
  localparam int ROLE_W    = 3;
  localparam int ROLES_W   = DED_COUNT * ROLE_W;
  localparam int SYNC_W    = 12;
  localparam int SYNC_BC1  = 0;
  localparam int SYNC_BC2  = 1;
  localparam int SYNC_ALD  = 2;
  localparam int SYNC_DATA = 3;
  localparam int SYNC_PAD  = 4;
  localparam int SYNC_DED  = 5;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

  // ****************************************
  // Modes and roles
  // ****************************************
  typedef enum logic [2:0] {
    MODE_CLEAR, MODE_PRESET_LOAD, MODE_PRESET_INV, MODE_PRESET_CLEAR,
    MODE_LOAD_CLEAR, MODE_LOAD_PRESET, MODE_LOAD_ONLY
  } crac_mode_type;

  typedef enum logic [1:0] {PIN_INPUT, PIN_OUTPUT, PIN_BIDIR} crac_pin_mode_type;

  typedef enum logic [2:0] {
    ROLE_DATA, ROLE_CLOCK, ROLE_CLEAR, ROLE_PRESET, ROLE_OE, ROLE_CLK_EN
  } crac_role_type;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic              oe;
    logic              clk_en;
    logic              out_inv;
    logic              in_inv;
    crac_pin_mode_type pin_mode;
    logic              chip_rst_en;
    crac_mode_type     mode;
  } crac_ctrl_type;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } crac_ahb_req_type;

  typedef struct packed {
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
  } crac_ahb_rsp_type;

endpackage
`default_nettype wire

// ===== verif/crac_cell_register_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module crac_cell_register_assertions (
  // Clock and reset
  input wire logic                       core_clk_i,
  input wire logic                       reset_i,
  // Register bus
  input wire crac_pkg::crac_ahb_req_type ahb_req_i,
  input wire crac_pkg::crac_ahb_rsp_type ahb_rsp_o,
  // Cell pins
  input wire logic                       block_control_one_i,
  input wire logic                       block_control_two_i,
  input wire logic                       async_load_data_i,
  input wire logic                       cell_data_i,
  input wire logic                       chip_reset_n_i,
  input wire logic [5:0]                 dedicated_i,
  input wire logic                       pad_i,
  input wire logic                       pad_o,
  input wire logic                       pad_oe_n_o,
  input wire logic                       cell_q_o,
  input wire logic                       pin_in_q_o
);
  // ****************************************
  // Shadow of the control register
  // ****************************************
  logic       wr_pend;
  logic       rd_pend;
  logic [9:0] ctrl_sh;
  wire        take = ahb_req_i.hsel && ahb_req_i.hready && ahb_req_i.htrans == 2'h2;
  wire  [2:0] md = ctrl_sh[2:0];
  wire        b1 = block_control_one_i;
  wire        b2 = block_control_two_i;
  wire        calm = chip_reset_n_i && dedicated_i == 6'h00;
  wire        quiet = calm && !b1 && !b2;

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ctrl_sh <= 10'h100;
    end
    else
    begin
      wr_pend <= take && ahb_req_i.hwrite && ahb_req_i.haddr == 32'h0;
      rd_pend <= take && !ahb_req_i.hwrite;
      if (wr_pend)
        ctrl_sh <= ahb_req_i.hwdata[9:0];
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  chk_rdata_idle: assert property (!rd_pend |-> ahb_rsp_o.hrdata == 32'h0)
    else $error("read data not zero outside data phase");
  chk_clear_path: assert property (
    ($stable(ctrl_sh) && calm && (((md == 3'h0 || md == 3'h7) && (b1 || b2))
    || ((md == 3'h3 || md == 3'h4) && b2)))[*5] |-> !cell_q_o)
    else $error("clear did not clear");
  chk_load_data: assert property (
    ($stable(ctrl_sh) && calm && md >= 3'h4 && md <= 3'h6 && b1 && !b2
    && $stable(async_load_data_i))[*5] |-> cell_q_o == async_load_data_i)
    else $error("load value wrong");
  chk_preset_one: assert property (
    ($stable(ctrl_sh) && calm && ((md == 3'h3 && b1 && !b2) || (md == 3'h2 && b1)
    || (md == 3'h1 && b1 && !b2 && async_load_data_i) || (md == 3'h5 && b2 && !b1)))[*5]
    |-> cell_q_o)
    else $error("preset did not set");
  chk_chip_reset: assert property (
    (!chip_reset_n_i && ctrl_sh[3] && $stable(ctrl_sh))[*5]
    |-> cell_q_o == (md == 3'h2 || md == 3'h5))
    else $error("chip reset not applied");
  chk_hold_value: assert property (
    (quiet && !ctrl_sh[8] && $stable(ctrl_sh))[*5] |-> $stable(cell_q_o))
    else $error("register changed while disabled");
  chk_capture_data: assert property (
    (quiet && ctrl_sh[8] && $stable(ctrl_sh) && $stable(cell_data_i))[*5]
    |-> cell_q_o == cell_data_i)
    else $error("data not captured");
  chk_pad_input: assert property (
    (quiet && ctrl_sh[8] && $stable(ctrl_sh) && $stable(pad_i) && !ctrl_sh[4])[*6]
    |-> pin_in_q_o == (pad_i ^ ctrl_sh[6]))
    else $error("pad input register wrong");
  chk_pad_output: assert property (
    (quiet && ctrl_sh[8] && $stable(ctrl_sh) && $stable(cell_data_i)
    && ctrl_sh[5:4] != 2'h0)[*7]
    |-> pad_o == (cell_q_o ^ ctrl_sh[7]) && pad_oe_n_o == !ctrl_sh[9])
    else $error("pad output register wrong");
endmodule // crac_cell_register_assertions

bind crac_cell_register crac_cell_register_assertions u_crac_cell_register_assertions (
  .core_clk_i, .reset_i, .ahb_req_i, .ahb_rsp_o, .block_control_one_i, .block_control_two_i,
  .async_load_data_i, .cell_data_i, .chip_reset_n_i, .dedicated_i, .pad_i, .pad_o,
  .pad_oe_n_o, .cell_q_o, .pin_in_q_o
);
`default_nettype wire

// ===== verif/crac_cell_register_test.sv
`timescale 1ns/100ps
`default_nettype none
module crac_cell_register_test;
  logic                       core_clk = 1'b0;
  logic                       reset = 1'b1;
  crac_pkg::crac_ahb_req_type rq = '0;
  crac_pkg::crac_ahb_req_type req;
  crac_pkg::crac_ahb_rsp_type rsp;
  logic                       bc1 = 1'b0;
  logic                       bc2 = 1'b0;
  logic                       ald = 1'b0;
  logic                       cd = 1'b0;
  logic                       crn = 1'b1;
  logic [5:0]                 ded = 6'h00;
  logic                       pad = 1'b0;
  logic                       pad_d;
  logic                       pad_oe_n;
  logic                       cell_q;
  logic                       pin_q;
  logic [31:0]                rd;
  logic [7:0]                 e;
  logic [7:0]                 tbl [17] = '{8'h18, 8'h14, 8'h2b, 8'h51, 8'h40, 8'h4b, 8'h69,
    8'h74, 8'h7c, 8'h8b, 8'h98, 8'h94, 8'hab, 8'hb8, 8'ha5, 8'hcb, 8'hd8};
  int                         err_count = 0;
  int                         check_count = 0;

  assign req = {rq[71:1], rsp.hreadyout};
  always #2 core_clk = ~core_clk;

  crac_cell_register u_crac_cell_register (
    .core_clk_i(core_clk), .reset_i(reset), .ahb_req_i(req), .ahb_rsp_o(rsp),
    .block_control_one_i(bc1), .block_control_two_i(bc2), .async_load_data_i(ald),
    .cell_data_i(cd), .chip_reset_n_i(crn), .dedicated_i(ded), .pad_i(pad), .pad_o(pad_d),
    .pad_oe_n_o(pad_oe_n), .cell_q_o(cell_q), .pin_in_q_o(pin_q)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    rq.hsel <= 1'b1;
    rq.haddr <= a;
    rq.htrans <= 2'h2;
    rq.hwrite <= w;
    rq.hsize <= 3'h2;
    @(posedge core_clk);
    while (rsp.hreadyout !== 1'b1) @(posedge core_clk);
    rq.hsel <= 1'b0;
    rq.htrans <= 2'h0;
    rq.hwdata <= d;
    @(posedge core_clk);
    while (rsp.hreadyout !== 1'b1) @(posedge core_clk);
    rd = rsp.hrdata;
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    cmp(rd, exp);
    cmp({31'h0, rsp.hresp}, 32'h0);
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    step(5000);
    err_count++;
    complete_run;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    step(6);
    reset <= 1'b0;
    step(1);
    rdc(32'h0, 32'h100);
    rdc(32'h4, 32'h0);
    xfer(32'h4, 1'b1, 32'hffff_ffff);
    rdc(32'h4, 32'h0003_ffff);
    xfer(32'h10, 1'b1, 32'h5);
    rdc(32'h10, 32'h0);
    xfer(32'h100, 1'b1, 32'h5);
    rdc(32'h0, 32'h100);
    xfer(32'h4, 1'b1, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 17; i++)
    begin
      e = tbl[i];
      xfer(32'h0, 1'b1, {23'h0, 1'b1, 5'h0, e[7:5]});
      cd <= e[4];
      step(6);
      bc1 <= e[3];
      bc2 <= e[2];
      ald <= e[1];
      step(6);
      cmp({31'h0, cell_q}, {31'h0, e[0]});
      bc1 <= 1'b0;
      bc2 <= 1'b0;
      ald <= 1'b0;
    end
    $display("test modes done");
    cd <= 1'b0;
    step(6);
    xfer(32'h0, 1'b1, 32'h0);
    cd <= 1'b1;
    step(6);
    cmp({31'h0, cell_q}, 32'h0);
    xfer(32'h0, 1'b1, 32'h100);
    step(6);
    cmp({31'h0, cell_q}, 32'h1);
    $display("test enable done");
    xfer(32'h0, 1'b1, 32'h10b);
    crn <= 1'b0;
    bc1 <= 1'b1;
    step(6);
    cmp({31'h0, cell_q}, 32'h0);
    xfer(32'h0, 1'b1, 32'h10d);
    step(6);
    cmp({31'h0, cell_q}, 32'h1);
    bc1 <= 1'b0;
    xfer(32'h0, 1'b1, 32'h103);
    step(6);
    cmp({31'h0, cell_q}, 32'h1);
    crn <= 1'b1;
    xfer(32'h0, 1'b1, 32'h10b);
    step(6);
    cmp({31'h0, cell_q}, 32'h1);
    $display("test chip reset done");
    xfer(32'h0, 1'b1, 32'h140);
    pad <= 1'b1;
    step(6);
    cmp({29'h0, pad_d, pad_oe_n, pin_q}, 32'h2);
    xfer(32'h0, 1'b1, 32'h390);
    step(6);
    cmp({30'h0, pad_d, pad_oe_n}, 32'h0);
    xfer(32'h0, 1'b1, 32'h320);
    pad <= 1'b0;
    step(6);
    cmp({29'h0, pad_d, pad_oe_n, pin_q}, 32'h4);
    $display("test pin cell done");
    xfer(32'h0, 1'b1, 32'h100);
    xfer(32'h4, 1'b1, 32'h11a);
    ded <= 6'h01;
    step(6);
    cmp({31'h0, cell_q}, 32'h0);
    ded <= 6'h02;
    cd <= 1'b0;
    step(6);
    cmp({31'h0, cell_q}, 32'h1);
    xfer(32'h8, 1'b0, 32'h0);
    cmp({26'h0, rd[8:3]}, 32'h2);
    xfer(32'h0, 1'b1, 32'h110);
    ded <= 6'h04;
    step(6);
    cmp({31'h0, pad_oe_n}, 32'h0);
    ded <= 6'h00;
    xfer(32'h4, 1'b1, 32'h0);
    $display("test dedicated done");
    complete_run;
  end
endmodule // crac_cell_register_test
`default_nettype wire
